// ### hdl/irq_csr_defs.vh
// constants for the slave interrupt and CSR control block
// assumes inclusion by bare name from each design file of the block that uses it
`ifndef IRQ_CSR_DEFS_VH
`define IRQ_CSR_DEFS_VH

`define ADDR_W 12
`define DATA_W 32
`define BE_W 4
`define OFS_LOCAL_IRQ_ENABLE 12'h000
`define OFS_LOCAL_IRQ_STATUS 12'h004
`define OFS_BUS_IRQ_ENABLE 12'h010
`define OFS_BUS_IRQ_STATUS 12'h014
`define OFS_CSR_BIT_CLEAR 12'h7F4
`define OFS_CSR_BIT_SET 12'h7F8
`define OFS_CONFIG_SPACE_BASE 12'h7FC
`define ZERO_32 32'h00000000

// local interrupt status / enable layout
`define LOCAL_IRQ_W 9
`define LIS_ACFAIL 0
`define LIS_SYSFAIL 1
`define LIS_SOFT_ACK 2
`define LIS_BUS_ERROR 3
`define LIS_MAILBOX_LO 4
`define LIS_MAILBOX_HI 7
`define LIS_GEO_PARITY 8
`define MAILBOX_N 4

// bus interrupter status / enable layout
`define BUS_IRQ_W 2
`define BIS_SOFT 0
`define BIS_USER 1

// csr bit set / bit clear layout
`define CSR_LOCAL_RESET 31
`define CSR_SYSFAIL_DRIVE 30
`define CSR_BUS_ERROR 27

// configuration space base field
`define BASE_HI 31
`define BASE_LO 27
`define BASE_W 5
`define BASE_ALL_ONES 5'h1F

// geographic pins and synchroniser
`define GEO_W 5
`define GEO_PARITY_GOOD 1'b1
`define SYNC_W 8
`define SYNC_ACFAIL 0
`define SYNC_SYSFAIL 1
`define SYNC_PARITY 2
`define SYNC_GEO_LO 3
`define SYNC_GEO_HI 7
`define INIT_W 2
`define INIT_WAIT 2'h3

// local reset hold time
`define LOCAL_RESET_HOLD_MS 200
`define CLK_MHZ 250
// 200 ms of 250 MHz clocks, sized to the hold counter
`define LOCAL_RESET_HOLD_CYCLES 26'h2FAF080
`define HOLD_CNT_W 26

`endif

// ### hdl/sync_bits.v
// two flip-flop synchroniser, one stage pair per bit
// assumes inputs are asynchronous levels; reset value is all zero
`timescale 1ns/1ns
module sync_bits #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst_b,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
        reg meta_reg;
        reg stable_reg;
        always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                meta_reg <= 1'b0;
                stable_reg <= 1'b0;
            end else begin
                meta_reg <= async_in[i];
                stable_reg <= meta_reg;
            end
        end
        assign sync_out[i] = stable_reg;
    end
endgenerate

endmodule

// ### hdl/reset_hold_timer.v
// local reset controller with a minimum hold time
// assumes start and release_req are single-cycle pulses on clk
`timescale 1ns/1ns
`include "irq_csr_defs.vh"
module reset_hold_timer #(
    parameter [`HOLD_CNT_W-1:0] HOLD_CYCLES = `LOCAL_RESET_HOLD_CYCLES
) (
    input wire clk,
    input wire rst_b,
    input wire start,
    input wire release_req,
    output wire active
);

reg [`HOLD_CNT_W-1:0] cnt_reg;
reg active_reg;
reg release_pend_reg;

wire hold_done = (cnt_reg == {`HOLD_CNT_W{1'b0}});

// a release before the hold time ends is remembered and honoured later
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        cnt_reg <= {`HOLD_CNT_W{1'b0}};
        active_reg <= 1'b0;
        release_pend_reg <= 1'b0;
    end else if (start) begin
        cnt_reg <= HOLD_CYCLES - 1'b1;
        active_reg <= 1'b1;
        release_pend_reg <= 1'b0;
    end else begin
        if (!hold_done)
            cnt_reg <= cnt_reg - 1'b1;
        if (active_reg && hold_done && (release_pend_reg || release_req)) begin
            active_reg <= 1'b0;
            release_pend_reg <= 1'b0;
        end else if (release_req && active_reg) begin
            release_pend_reg <= 1'b1;
        end
    end
end

assign active = active_reg;

endmodule

// ### hdl/slave_irq_and_csr_control.v
// interrupt status/enable, csr bit set/clear and configuration base registers
// assumes event pulses come from logic on clk; pins are synchronised here
// Summary of operation
// - interrupter status holds user pending in bit 1, software pending in bit 0.
// - software pending clears itself when an acknowledge cycle serves it.
// - writing one clears a status flag; writing zero leaves it.
// - status flags record events regardless of enables.
// - interrupter enables in bits 1 and 0 gate pending requests onto the bus.
// - active-low cpu interrupt asserts while any enabled local flag is set.
// - local status: 8 parity, 7..4 mailboxes, 3 bus error, 2 ack, 1 sysfail, 0 acfail.
// - a bus write to mailbox n sets mailbox n flag.
// - bus error flag sets when bus error terminates the current cycle.
// - software acknowledge flag sets once the software request is served.
// - sysfail and acfail flags set while those inputs are asserted.
// - local enable mirrors status bits 8..0; one enables, zero disables.
// - clear bit 31 releases local reset; bit 31 reads one while reset asserted.
// - set bit 31 asserts local reset, held for at least 200 ms.
// - bit 30 set/clear drives and releases sysfail driver; reads its state.
// - bit 27 is bus error state, set by driving bus error or set write.
// - set and clear registers read live state, not written values.
// - base field 31:27 loads from geographic pins, software may overwrite it.
// - device selected for config space when base equals address bits 23:19.
// - geographic parity mismatch loads base with ones and sets parity flag.
// - software request acknowledged by acknowledge cycle or writing one to its flag.
// - any mailbox data write raises that mailbox's local interrupt source.
`timescale 1ns/1ns
`include "irq_csr_defs.vh"
module slave_irq_and_csr_control #(
    parameter [`HOLD_CNT_W-1:0] RESET_HOLD_CYCLES = `LOCAL_RESET_HOLD_CYCLES
) (
    input wire clk,
    input wire rst_b,
    input wire [`ADDR_W-1:0] lb_addr,
    input wire lb_wr,
    input wire lb_rd,
    input wire [`BE_W-1:0] lb_be,
    input wire [`DATA_W-1:0] lb_wdata,
    output wire lb_ready,
    output reg [`DATA_W-1:0] lb_rdata,
    output reg lb_rd_valid,
    input wire [`ADDR_W-1:0] vme_reg_addr,
    input wire vme_reg_wr,
    input wire vme_reg_rd,
    input wire [`BE_W-1:0] vme_reg_be,
    input wire [`DATA_W-1:0] vme_reg_wdata,
    output reg [`DATA_W-1:0] vme_reg_rdata,
    output reg vme_reg_rd_valid,
    input wire [`BASE_W-1:0] vme_addr_hi,
    output wire cr_csr_select,
    input wire soft_req_set,
    input wire soft_iack_served,
    input wire user_irq_req,
    input wire [`MAILBOX_N-1:0] mailbox_write,
    input wire berr_driven,
    input wire sysfail_in_b,
    input wire acfail_in_b,
    input wire [`GEO_W-1:0] geo_addr_b,
    input wire geo_parity_pin,
    output wire bus_irq_soft,
    output wire bus_irq_user,
    output wire local_int_b,
    output wire local_reset_b,
    output wire sysfail_drive_out_b
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisation and geographic load

wire [`SYNC_W-1:0] pins_sync;

sync_bits #(
    .WIDTH(`SYNC_W)
) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in({geo_addr_b, geo_parity_pin, ~sysfail_in_b, ~acfail_in_b}),
    .sync_out(pins_sync)
);

wire sysfail_act = pins_sync[`SYNC_SYSFAIL];
wire acfail_act = pins_sync[`SYNC_ACFAIL];
wire [`GEO_W-1:0] geo_b = pins_sync[`SYNC_GEO_HI:`SYNC_GEO_LO];
wire geo_parity_ok = ((^geo_b) ^ pins_sync[`SYNC_PARITY]) == `GEO_PARITY_GOOD;

reg [`INIT_W-1:0] init_cnt_reg;
reg geo_loaded_reg;
// synchroniser output is valid once the wait count has elapsed
wire geo_load = !geo_loaded_reg && (init_cnt_reg == `INIT_WAIT);

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        init_cnt_reg <= {`INIT_W{1'b0}};
        geo_loaded_reg <= 1'b0;
    end else begin
        if (init_cnt_reg != `INIT_WAIT)
            init_cnt_reg <= init_cnt_reg + 1'b1;
        if (geo_load)
            geo_loaded_reg <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register write merge: bus side wins, local side stalls

assign lb_ready = !vme_reg_wr;

wire wr_any = vme_reg_wr || lb_wr;
wire [`ADDR_W-1:0] wr_addr = vme_reg_wr ? vme_reg_addr : lb_addr;
wire [`BE_W-1:0] wr_be = vme_reg_wr ? vme_reg_be : lb_be;
wire [`DATA_W-1:0] wr_raw = vme_reg_wr ? vme_reg_wdata : lb_wdata;
wire [`DATA_W-1:0] wr_data = wr_raw & {{8{wr_be[3]}}, {8{wr_be[2]}},
    {8{wr_be[1]}}, {8{wr_be[0]}}};

// low address bits ignored, every register is one word
wire [`ADDR_W-1:0] wr_word = {wr_addr[`ADDR_W-1:2], 2'b00};
wire wr_lie = wr_any && (wr_word == `OFS_LOCAL_IRQ_ENABLE);
wire wr_lis = wr_any && (wr_word == `OFS_LOCAL_IRQ_STATUS);
wire wr_bie = wr_any && (wr_word == `OFS_BUS_IRQ_ENABLE);
wire wr_bis = wr_any && (wr_word == `OFS_BUS_IRQ_STATUS);
wire wr_clr = wr_any && (wr_word == `OFS_CSR_BIT_CLEAR);
wire wr_set = wr_any && (wr_word == `OFS_CSR_BIT_SET);
// base field moves only with its top byte lane enabled
wire wr_base = wr_any && (wr_word == `OFS_CONFIG_SPACE_BASE) && wr_be[3];

////////////////////////////////////////////////////////////////////////////////
// bus interrupter status and enable

reg [`BUS_IRQ_W-1:0] bus_irq_status_reg;
reg [`BUS_IRQ_W-1:0] bus_irq_enable_reg;
reg [`BUS_IRQ_W-1:0] bus_irq_status_next;

// served either by an acknowledge cycle or by a one written to its flag
wire soft_w1c = wr_bis && wr_data[`BIS_SOFT];
wire soft_served = bus_irq_status_reg[`BIS_SOFT]
    && (soft_iack_served || soft_w1c);

always @* begin
    bus_irq_status_next = bus_irq_status_reg;
    if (wr_bis)
        bus_irq_status_next = bus_irq_status_next & ~wr_data[`BUS_IRQ_W-1:0];
    if (soft_iack_served)
        bus_irq_status_next[`BIS_SOFT] = 1'b0;
    // new requests win over a clear in the same cycle
    if (soft_req_set)
        bus_irq_status_next[`BIS_SOFT] = 1'b1;
    if (user_irq_req)
        bus_irq_status_next[`BIS_USER] = 1'b1;
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        bus_irq_status_reg <= {`BUS_IRQ_W{1'b0}};
        bus_irq_enable_reg <= {`BUS_IRQ_W{1'b0}};
    end else begin
        bus_irq_status_reg <= bus_irq_status_next;
        if (wr_bie)
            bus_irq_enable_reg <= wr_data[`BUS_IRQ_W-1:0];
    end
end

assign bus_irq_soft = bus_irq_status_reg[`BIS_SOFT] && bus_irq_enable_reg[`BIS_SOFT];
assign bus_irq_user = bus_irq_status_reg[`BIS_USER] && bus_irq_enable_reg[`BIS_USER];

////////////////////////////////////////////////////////////////////////////////
// local interrupt controller

reg [`LOCAL_IRQ_W-1:0] local_irq_status_reg;
reg [`LOCAL_IRQ_W-1:0] local_irq_enable_reg;
reg [`LOCAL_IRQ_W-1:0] local_irq_status_next;
reg [`LOCAL_IRQ_W-1:0] local_irq_set;

always @* begin
    local_irq_set = {`LOCAL_IRQ_W{1'b0}};
    local_irq_set[`LIS_GEO_PARITY] = geo_load && !geo_parity_ok;
    local_irq_set[`LIS_MAILBOX_HI:`LIS_MAILBOX_LO] = mailbox_write;
    local_irq_set[`LIS_BUS_ERROR] = berr_driven;
    local_irq_set[`LIS_SOFT_ACK] = soft_served;
    local_irq_set[`LIS_SYSFAIL] = sysfail_act;
    local_irq_set[`LIS_ACFAIL] = acfail_act;
    local_irq_status_next = local_irq_status_reg;
    if (wr_lis)
        local_irq_status_next = local_irq_status_next & ~wr_data[`LOCAL_IRQ_W-1:0];
    local_irq_status_next = local_irq_status_next | local_irq_set;
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        local_irq_status_reg <= {`LOCAL_IRQ_W{1'b0}};
        local_irq_enable_reg <= {`LOCAL_IRQ_W{1'b0}};
    end else begin
        local_irq_status_reg <= local_irq_status_next;
        if (wr_lie)
            local_irq_enable_reg <= wr_data[`LOCAL_IRQ_W-1:0];
    end
end

// any enabled flag pulls the cpu interrupt low
assign local_int_b = ~|(local_irq_status_reg & local_irq_enable_reg);

////////////////////////////////////////////////////////////////////////////////
// csr bit set / bit clear state

// local reset leaves only through the hold timer, never early
wire local_reset_active;

reset_hold_timer #(
    .HOLD_CYCLES(RESET_HOLD_CYCLES)
) u_reset_hold (
    .clk(clk),
    .rst_b(rst_b),
    .start(wr_set && wr_data[`CSR_LOCAL_RESET]),
    .release_req(wr_clr && wr_data[`CSR_LOCAL_RESET]),
    .active(local_reset_active)
);

assign local_reset_b = !local_reset_active;

reg sysfail_drive_ctl_reg;
reg bus_error_state_reg;

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        sysfail_drive_ctl_reg <= 1'b0;
        bus_error_state_reg <= 1'b0;
    end else begin
        if (wr_set && wr_data[`CSR_SYSFAIL_DRIVE])
            sysfail_drive_ctl_reg <= 1'b1;
        else if (wr_clr && wr_data[`CSR_SYSFAIL_DRIVE])
            sysfail_drive_ctl_reg <= 1'b0;
        // hardware set wins over a clear write
        if (berr_driven || (wr_set && wr_data[`CSR_BUS_ERROR]))
            bus_error_state_reg <= 1'b1;
        else if (wr_clr && wr_data[`CSR_BUS_ERROR])
            bus_error_state_reg <= 1'b0;
    end
end

assign sysfail_drive_out_b = !sysfail_drive_ctl_reg;

////////////////////////////////////////////////////////////////////////////////
// configuration space base

reg [`BASE_W-1:0] config_space_base_reg;

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        config_space_base_reg <= `BASE_ALL_ONES;
    end else if (geo_load) begin
        config_space_base_reg <= geo_parity_ok ? ~geo_b : `BASE_ALL_ONES;
    end else if (wr_base) begin
        config_space_base_reg <= wr_data[`BASE_HI:`BASE_LO];
    end
end

// compared against address bits 23:19 of the current transfer
assign cr_csr_select = (config_space_base_reg == vme_addr_hi);

////////////////////////////////////////////////////////////////////////////////
// read decode

// unmapped offsets and reserved bits read as zero
function [`DATA_W-1:0] read_word;
    input [`ADDR_W-1:0] addr;
    // set and clear views both report live state
    reg [`DATA_W-1:0] csr_live;
    begin
        csr_live = `ZERO_32;
        csr_live[`CSR_LOCAL_RESET] = local_reset_active;
        csr_live[`CSR_SYSFAIL_DRIVE] = sysfail_drive_ctl_reg;
        csr_live[`CSR_BUS_ERROR] = bus_error_state_reg;
        read_word = `ZERO_32;
        case ({addr[`ADDR_W-1:2], 2'b00})
            `OFS_LOCAL_IRQ_ENABLE: read_word[`LOCAL_IRQ_W-1:0] = local_irq_enable_reg;
            `OFS_LOCAL_IRQ_STATUS: read_word[`LOCAL_IRQ_W-1:0] = local_irq_status_reg;
            `OFS_BUS_IRQ_ENABLE: read_word[`BUS_IRQ_W-1:0] = bus_irq_enable_reg;
            `OFS_BUS_IRQ_STATUS: read_word[`BUS_IRQ_W-1:0] = bus_irq_status_reg;
            `OFS_CSR_BIT_CLEAR: read_word = csr_live;
            `OFS_CSR_BIT_SET: read_word = csr_live;
            `OFS_CONFIG_SPACE_BASE: read_word[`BASE_HI:`BASE_LO] = config_space_base_reg;
            default: read_word = `ZERO_32;
        endcase
    end
endfunction

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        lb_rdata <= `ZERO_32;
        lb_rd_valid <= 1'b0;
        vme_reg_rdata <= `ZERO_32;
        vme_reg_rd_valid <= 1'b0;
    end else begin
        // answer one cycle after the strobe, data held until the next read
        lb_rd_valid <= lb_rd;
        if (lb_rd)
            lb_rdata <= read_word(lb_addr);
        vme_reg_rd_valid <= vme_reg_rd;
        if (vme_reg_rd)
            vme_reg_rdata <= read_word(vme_reg_addr);
    end
end

endmodule

// ### tb/backplane_model.sv
// backplane pin model: slot address, its parity and the failure lines
// assumes the bench picks slot, parity fault and failure levels
`timescale 1ns/1ns
module backplane_model (
    input wire [4:0] slot,
    input wire bad_par,
    input wire sf,
    input wire af,
    output wire [4:0] geo_addr_b,
    output wire geo_parity_pin,
    output wire sysfail_in_b,
    output wire acfail_in_b
);
    assign geo_addr_b = ~slot;
    // odd parity over pins when good, broken on request
    assign geo_parity_pin = ~(^geo_addr_b) ^ bad_par;
    assign sysfail_in_b = ~sf;
    assign acfail_in_b = ~af;
endmodule

// ### tb/irq_csr_checker_asserts.sv
// port assertions for the interrupt and csr control block
// assumes a bind onto the top design module, single clock domain
`timescale 1ns/1ns
`include "irq_csr_defs.vh"
module irq_csr_checker #(
    parameter [`HOLD_CNT_W-1:0] HOLD = 16
) (
    input wire clk,
    input wire rst_b,
    input wire [`ADDR_W-1:0] lb_addr,
    input wire lb_wr,
    input wire lb_rd,
    input wire [`BE_W-1:0] lb_be,
    input wire [`DATA_W-1:0] lb_wdata,
    input wire lb_ready,
    input wire lb_rd_valid,
    input wire vme_reg_wr,
    input wire [`BASE_W-1:0] vme_addr_hi,
    input wire cr_csr_select,
    input wire soft_req_set,
    input wire soft_iack_served,
    input wire user_irq_req,
    input wire bus_irq_soft,
    input wire bus_irq_user,
    input wire local_int_b,
    input wire local_reset_b,
    input wire sysfail_drive_out_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire lw = lb_wr && lb_ready && lb_be[3];
    reg [`HOLD_CNT_W-1:0] low_cnt;
    // cycles the local reset has been low
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b || local_reset_b)
            low_cnt <= {`HOLD_CNT_W{1'b0}};
        else
            low_cnt <= low_cnt + 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    property p_rst_set;
        lw && lb_addr == `OFS_CSR_BIT_SET && lb_wdata[31] |=> !local_reset_b;
    endproperty
    a_rst_set: assert property (p_rst_set) else $error("local reset not asserted");
    property p_rst_hold;
        $rose(local_reset_b) |-> low_cnt >= HOLD;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("local reset too short");
    property p_sf_set;
        lw && lb_addr == `OFS_CSR_BIT_SET && lb_wdata[30] |=> !sysfail_drive_out_b;
    endproperty
    a_sf_set: assert property (p_sf_set) else $error("sysfail drive not set");
    property p_sf_clr;
        lw && lb_addr == `OFS_CSR_BIT_CLEAR && lb_wdata[30] |=> sysfail_drive_out_b;
    endproperty
    a_sf_clr: assert property (p_sf_clr) else $error("sysfail drive not released");
    property p_base;
        lw && lb_addr == `OFS_CONFIG_SPACE_BASE
            |=> cr_csr_select == (vme_addr_hi == $past(lb_wdata[31:27]));
    endproperty
    a_base: assert property (p_base) else $error("select does not follow base");
    property p_iack;
        soft_iack_served && !soft_req_set |=> !bus_irq_soft;
    endproperty
    a_iack: assert property (p_iack) else $error("soft request kept after ack");
    property p_user;
        $rose(bus_irq_user) |-> $past(user_irq_req) || $past(lb_wr) || $past(vme_reg_wr);
    endproperty
    a_user: assert property (p_user) else $error("user request without cause");
    property p_int_rise;
        $rose(local_int_b) |-> $past(lb_wr || vme_reg_wr);
    endproperty
    a_int_rise: assert property (p_int_rise) else $error("cpu interrupt dropped alone");
    property p_rd;
        lb_rd |=> lb_rd_valid;
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    c_rst: cover property ($fell(local_reset_b));
    c_sel: cover property (cr_csr_select);
    c_int: cover property ($fell(local_int_b));
endmodule
bind slave_irq_and_csr_control irq_csr_checker #(.HOLD(RESET_HOLD_CYCLES)) irq_csr_checker_inst (
    .clk, .rst_b, .lb_addr, .lb_wr, .lb_rd, .lb_be, .lb_wdata, .lb_ready, .lb_rd_valid,
    .vme_reg_wr, .vme_addr_hi, .cr_csr_select, .soft_req_set, .soft_iack_served,
    .user_irq_req, .bus_irq_soft, .bus_irq_user, .local_int_b, .local_reset_b,
    .sysfail_drive_out_b);

// ### tb/test_slave_irq_and_csr_control.sv
// self-checking bench: reads queue expectations, a monitor compares answers
// assumes the design headers are on the include path
`timescale 1ns/1ns
`include "irq_csr_defs.vh"
module test_slave_irq_and_csr_control;
    localparam [`HOLD_CNT_W-1:0] HOLD = 16;
    logic clk = 0, rst_b = 0, lb_wr = 0, lb_rd = 0, vme_reg_wr = 0, vme_reg_rd = 0;
    logic [11:0] lb_addr = 0, vme_reg_addr = 0;
    logic [3:0] lb_be = 0, vme_reg_be = 0, mailbox_write = 0;
    logic [31:0] lb_wdata = 0, vme_reg_wdata = 0;
    logic [4:0] vme_addr_hi = 0, slot = 5'h0B, b;
    logic soft_req_set = 0, soft_iack_served = 0, user_irq_req = 0, berr_driven = 0;
    logic bad_par = 0, sf = 0, af = 0;
    wire lb_ready, lb_rd_valid, vme_reg_rd_valid, cr_csr_select, bus_irq_soft, bus_irq_user;
    wire local_int_b, local_reset_b, sysfail_drive_out_b, sysfail_in_b, acfail_in_b;
    wire geo_parity_pin;
    wire [31:0] lb_rdata, vme_reg_rdata;
    wire [4:0] geo_addr_b;
    int fail_count = 0, check_count = 0, n;
    logic [31:0] exp_q[$];
    logic [7:0] r = 8'h5B;
    logic [11:0] ra[8] = '{12'h000, 12'h004, 12'h010, 12'h014, 12'h7F4, 12'h7F8, 12'h7FC, 12'h100};
    always #2 clk = ~clk;
    slave_irq_and_csr_control #(.RESET_HOLD_CYCLES(HOLD)) slave_irq_and_csr_control_inst (
        .clk, .rst_b, .lb_addr, .lb_wr, .lb_rd, .lb_be, .lb_wdata, .lb_ready, .lb_rdata,
        .lb_rd_valid, .vme_reg_addr, .vme_reg_wr, .vme_reg_rd, .vme_reg_be, .vme_reg_wdata,
        .vme_reg_rdata, .vme_reg_rd_valid, .vme_addr_hi, .cr_csr_select, .soft_req_set,
        .soft_iack_served, .user_irq_req, .mailbox_write, .berr_driven, .sysfail_in_b,
        .acfail_in_b, .geo_addr_b, .geo_parity_pin, .bus_irq_soft, .bus_irq_user,
        .local_int_b, .local_reset_b, .sysfail_drive_out_b);
    backplane_model backplane_model_inst (.slot, .bad_par, .sf, .af, .geo_addr_b,
        .geo_parity_pin, .sysfail_in_b, .acfail_in_b);
    function logic [7:0] lfsr(logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cyc(int k);
        repeat (k) @(negedge clk);
    endtask
    task wr(bit v, logic [11:0] ad, logic [31:0] d);
        @(negedge clk);
        if (v) {vme_reg_wr, vme_reg_addr, vme_reg_wdata, vme_reg_be} = {1'b1, ad, d, 4'hF};
        else {lb_wr, lb_addr, lb_wdata, lb_be} = {1'b1, ad, d, 4'hF};
        @(negedge clk);
        {vme_reg_wr, lb_wr} = 0;
    endtask
    task rd(bit v, logic [11:0] ad, logic [31:0] e);
        @(negedge clk);
        exp_q.push_back(e);
        if (v) {vme_reg_rd, vme_reg_addr} = {1'b1, ad};
        else {lb_rd, lb_addr} = {1'b1, ad};
        @(negedge clk);
        {vme_reg_rd, lb_rd} = 0;
    endtask
    task ev(logic [6:0] m);
        @(negedge clk);
        {soft_req_set, soft_iack_served, berr_driven, mailbox_write} = m;
        @(negedge clk);
        {soft_req_set, soft_iack_served, berr_driven, mailbox_write} = 0;
    endtask
    task do_reset;
        rst_b = 0;
        cyc(16);
        rst_b = 1;
        cyc(12);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // read answers, oldest expectation first
    always @(negedge clk) begin
        if (lb_rd_valid || vme_reg_rd_valid) begin
            if (exp_q.size() == 0) chk("unexpected read", 0, 1);
            else chk("read data", exp_q.pop_front(), lb_rd_valid ? lb_rdata : vme_reg_rdata);
        end
    end
    initial begin
        #100000;
        fail_count++;
        end_of_test;
    end
    initial begin
        do_reset;
        foreach (ra[i]) rd(i[0], ra[i], i == 6 ? {slot, 27'h0} : 0);
        $display("test reset values done");
        vme_addr_hi = slot;
        cyc(1);
        chk("select", 1, cr_csr_select);
        r = lfsr(r);
        b = r[4:0];
        wr(0, 12'h7FC, {b, 27'h7FFFFFF});
        rd(1, 12'h7FC, {b, 27'h0});
        vme_addr_hi = b;
        cyc(1);
        chk("select", 1, cr_csr_select);
        vme_addr_hi = ~b;
        cyc(1);
        chk("select", 0, cr_csr_select);
        @(negedge clk);
        {lb_wr, lb_addr, lb_wdata, lb_be} = {1'b1, 12'h7FC, 32'hFFFFFFFF, 4'h7};
        @(negedge clk);
        lb_wr = 0;
        rd(1, 12'h7FC, {b, 27'h0});
        $display("test base done");
        r = lfsr(r);
        ev({3'b001, r[3:0] | 4'h1});
        rd(0, 12'h004, {r[3:0] | 4'h1, 4'h8});
        rd(0, 12'h7F8, 32'h08000000);
        chk("cpu int", 1, local_int_b);
        wr(0, 12'h000, 32'hFFFFFFFF);
        rd(1, 12'h000, 32'h1FF);
        chk("cpu int", 0, local_int_b);
        wr(1, 12'h004, 0);
        rd(0, 12'h004, {r[3:0] | 4'h1, 4'h8});
        wr(1, 12'h004, 32'h1FF);
        chk("cpu int", 1, local_int_b);
        wr(0, 12'h7F4, 32'h08000000);
        rd(1, 12'h7F8, 0);
        sf = 1;
        cyc(4);
        {sf, af} = 2'b01;
        cyc(4);
        af = 0;
        cyc(3);
        rd(0, 12'h004, 3);
        wr(0, 12'h004, 3);
        $display("test local events done");
        wr(0, 12'h010, 2);
        ev(7'h40);
        chk("soft irq", 0, bus_irq_soft);
        wr(0, 12'h010, 3);
        chk("soft irq", 1, bus_irq_soft);
        rd(1, 12'h014, 1);
        ev(7'h20);
        chk("soft irq", 0, bus_irq_soft);
        rd(0, 12'h004, 4);
        wr(0, 12'h004, 4);
        ev(7'h40);
        wr(1, 12'h014, 1);
        rd(0, 12'h014, 0);
        rd(0, 12'h004, 4);
        user_irq_req = 1;
        cyc(1);
        chk("user irq", 1, bus_irq_user);
        wr(1, 12'h014, 2);
        rd(1, 12'h014, 2);
        user_irq_req = 0;
        wr(1, 12'h014, 2);
        rd(1, 12'h014, 0);
        chk("user irq", 0, bus_irq_user);
        $display("test bus requests done");
        @(negedge clk);
        {vme_reg_wr, vme_reg_addr, vme_reg_wdata, vme_reg_be} = {1'b1, 12'h010, 32'h0, 4'hF};
        {lb_wr, lb_addr, lb_wdata, lb_be} = {1'b1, 12'h000, 32'h0, 4'hF};
        #1 chk("ready", 0, lb_ready);
        @(negedge clk);
        {vme_reg_wr, lb_wr} = 0;
        rd(0, 12'h000, 32'h1FF);
        rd(1, 12'h010, 0);
        wr(0, 12'h7F8, 32'h40000000);
        chk("sysfail drive", 0, sysfail_drive_out_b);
        rd(1, 12'h7F4, 32'h40000000);
        wr(0, 12'h7F4, 32'h40000000);
        chk("sysfail drive", 1, sysfail_drive_out_b);
        wr(0, 12'h7F8, 32'h80000000);
        rd(0, 12'h7F4, 32'h80000000);
        wr(1, 12'h7F4, 32'h80000000);
        chk("local reset", 0, local_reset_b);
        for (n = 0; n < 40 && !local_reset_b; n++) cyc(1);
        chk("local reset", 1, local_reset_b);
        if (local_reset_b !== 1'b1) end_of_test;
        chk("reset hold", 1, n >= HOLD - 4);
        rd(1, 12'h7F8, 0);
        $display("test csr done");
        bad_par = 1;
        do_reset;
        rd(0, 12'h7FC, 32'hF8000000);
        rd(1, 12'h004, 32'h100);
        cyc(3);
        chk("queue empty", 0, exp_q.size());
        $display("test parity done");
        end_of_test;
    end
endmodule
